// >>> common/dtg_pkg.sv
// package: ddr2 command spacing constants, command codes and carriers
package dtg_pkg;

  // ****************************************************
  // clock and timing figures
  // ****************************************************
  localparam int CLK_PERIOD_PS  = 25000;   // 40 MHz controller clock
  localparam int TCK_MIN_PS     = 3000;
  localparam int TCK_MAX_PS     = 8000;
  localparam int TMRD_CK        = 2;
  localparam int TRAS_MIN_PS    = 45000;
  localparam int TRAS_MAX_PS    = 70000000;
  localparam int TRCD_PS        = 15000;
  localparam int TRRD_PS        = 7500;
  localparam int TCCD_CK        = 2;
  localparam int TWR_PS         = 15000;
  localparam int TRP_PS         = 15000;
  localparam int TWTR_CK        = 2;
  localparam int TRTP_PS        = 7500;
  localparam int TRFC_PS        = 127500;
  localparam int TXSNR_EXTRA_PS = 10000;
  localparam int TXSRD_CK       = 200;
  localparam int TXP_CK         = 2;
  localparam int TXARD_CK       = 2;
  localparam int TCKE_CK        = 3;
  localparam int TDQSS_QTR      = 1;       // quarter cycles of slack

  // ps minimums rounded up to whole clocks; a longest time rounds down
  function automatic int ceil_ck(input int ps);
    int r;
    r = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (r < 1) ? 1 : r;
  endfunction

  localparam int TRAS_CK   = ceil_ck(TRAS_MIN_PS);
  localparam int TRASX_CK  = TRAS_MAX_PS / CLK_PERIOD_PS;
  localparam int TRCD_CK   = ceil_ck(TRCD_PS);
  localparam int TRRD_CK   = ceil_ck(TRRD_PS);
  localparam int TRTP_CK   = ceil_ck(TRTP_PS);
  localparam int TDAL_CK   = ceil_ck(TWR_PS) + ceil_ck(TRP_PS);
  localparam int TXSNR_CK  = ceil_ck(TRFC_PS + TXSNR_EXTRA_PS);

  localparam int BANKS     = 8;
  localparam int BANK_W    = 3;
  localparam int ROW_W     = 14;
  localparam int COL_W     = 10;
  localparam int CNT_W     = 16;
  localparam int XCNT_W    = 8;

  // ****************************************************
  // commands and carriers
  // ****************************************************
  typedef enum logic [3:0] {
    CMD_NOP, CMD_ACT, CMD_RD, CMD_RDA, CMD_WR, CMD_WRA, CMD_PRE,
    CMD_MRS, CMD_REF, CMD_SRE, CMD_SRX, CMD_PDE, CMD_PDX, CMD_APDX
  } dtg_cmd_t;

  typedef struct packed {
    dtg_cmd_t                cmd;
    logic [BANK_W-1:0]       bank;
    logic [ROW_W-1:0]        addr;
  } dtg_req_t;

  typedef struct packed {
    logic                    cke;
    logic                    cs_n;
    logic                    ras_n;
    logic                    cas_n;
    logic                    we_n;
    logic [BANK_W-1:0]       ba;
    logic [ROW_W-1:0]        a;
  } dtg_pins_t;

endpackage : dtg_pkg

// >>> hdl/dtg_bank_timer.sv
// per-bank spacing timers for one ddr2 bank
`timescale 1ns/100ps
`default_nettype none
module dtg_bank_timer #(
  parameter int CW = dtg_pkg::CNT_W,
  parameter int WB = 5  // write latency plus half burst
) (
  input  wire logic          clock,        // controller clock
  input  wire logic          rst,          // sync reset, high
  input  wire logic          act,          // activate this bank
  input  wire logic          rd,           // read to this bank
  input  wire logic          wr,           // write to this bank
  input  wire logic          ap,           // column cmd auto-precharges
  input  wire logic          pre,          // precharge this bank
  output logic               open,         // row open
  output logic               col_ok,       // column cmd allowed
  output logic               pre_ok,       // precharge allowed
  output logic               act_ok,       // activate allowed
  output logic               ras_late      // row open near its limit
);
  logic [CW-1:0] ras_cnt, next_ras_cnt;   // cycles since activate
  logic [CW-1:0] rcd, next_rcd;
  logic [CW-1:0] rtp, next_rtp;
  logic [CW-1:0] rp, next_rp;
  logic          next_open;

  always_comb begin
    next_open    = open;
    next_ras_cnt = (ras_cnt != '1) ? ras_cnt + 1'b1 : ras_cnt;
    next_rcd     = (rcd != '0) ? rcd - 1'b1 : rcd;
    next_rtp     = (rtp != '0) ? rtp - 1'b1 : rtp;
    next_rp      = (rp != '0) ? rp - 1'b1 : rp;
    if (act) begin
      next_open    = 1'b1;
      next_ras_cnt = '0;
      next_rcd     = CW'(dtg_pkg::TRCD_CK - 1);
    end
    if (rd) begin
      next_rtp = CW'(dtg_pkg::TRTP_CK - 1);
    end
    if ((rd || wr) && ap) begin
      next_open = 1'b0;
      // write auto-precharge: write latency plus half burst, then recovery plus precharge period
      next_rp   = wr ? CW'(WB + dtg_pkg::TDAL_CK - 1)
                     : CW'(dtg_pkg::TRTP_CK + dtg_pkg::ceil_ck(dtg_pkg::TRP_PS) - 1);
    end
    if (pre) begin
      next_open = 1'b0;
      next_rp   = CW'(dtg_pkg::ceil_ck(dtg_pkg::TRP_PS) - 1);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      open    <= 1'b0;
      ras_cnt <= '0;
      rcd     <= '0;
      rtp     <= '0;
      rp      <= '0;
    end else begin
      open    <= next_open;
      ras_cnt <= next_ras_cnt;
      rcd     <= next_rcd;
      rtp     <= next_rtp;
      rp      <= next_rp;
    end
  end

  assign col_ok   = open && (rcd == '0);
  assign pre_ok   = (ras_cnt >= CW'(dtg_pkg::TRAS_CK - 1))
                    && (rtp == '0);
  assign act_ok   = !open && (rp == '0)
                    && (ras_cnt >= CW'(dtg_pkg::TRAS_CK - 1));
  // saturating counter: needs CW wide enough for the open limit
  assign ras_late = open && (ras_cnt >= CW'(dtg_pkg::TRASX_CK - 2));
endmodule // dtg_bank_timer
`default_nettype wire

// >>> hdl/dtg_ctrl.sv
// ddr2 command issuer that enforces the device's command spacing
`timescale 1ns/100ps
`default_nettype none
module dtg_ctrl #(
  parameter int WRITE_LATENCY = 3,   // programmed write latency, clocks
  parameter int BURST_LEN     = 4,   // data beats per burst
  parameter int XSRD          = dtg_pkg::TXSRD_CK
) (
  input  wire logic              clock,     // 40 MHz controller clock
  input  wire logic              rst,       // sync reset, high
  input  wire dtg_pkg::dtg_req_t req,       // requested command
  input  wire logic              req_valid, // request present
  output logic                   req_ready, // request would be taken this cycle
  output dtg_pkg::dtg_pins_t     pins,      // command pins, registered
  output logic                   dqs_en,    // write strobe window
  output logic                   row_expire // some open row near limit
);
  // ****************************************************
  // decode of the request
  // ****************************************************
  localparam int XW = dtg_pkg::XCNT_W;
  dtg_pkg::dtg_cmd_t c;
  logic [dtg_pkg::BANKS-1:0] bsel, b_open, b_col, b_pre, b_act, b_late;
  logic [dtg_pkg::BANKS-1:0] b_actp, b_rdp, b_wrp, b_prep;
  logic is_rd, is_wr, is_col, is_ap, allowed, go;
  logic all_closed;

  assign c      = req.cmd;
  assign bsel   = dtg_pkg::BANKS'(1) << req.bank;
  assign is_rd  = (c == dtg_pkg::CMD_RD) || (c == dtg_pkg::CMD_RDA);
  assign is_wr  = (c == dtg_pkg::CMD_WR) || (c == dtg_pkg::CMD_WRA);
  assign is_col = is_rd || is_wr;
  assign is_ap  = (c == dtg_pkg::CMD_RDA) || (c == dtg_pkg::CMD_WRA);
  assign all_closed = (b_open == '0);

  // ****************************************************
  // shared spacing counters
  // ****************************************************
  logic [XW-1:0] mrd, next_mrd;     // after mode register set
  logic [XW-1:0] rrd, next_rrd;     // activate to activate
  logic [XW-1:0] ccd, next_ccd;     // column to column
  logic [XW-1:0] wtr, next_wtr;     // write data end to read
  logic [XW-1:0] xnr, next_xnr;     // exit to non-read
  logic [XW-1:0] xrd, next_xrd;     // exit to read
  logic [XW-1:0] cke_hold, next_cke_hold;
  logic [XW-1:0] wl_cnt, next_wl_cnt;  // write latency then burst
  logic          cke, next_cke;
  logic          wpend, next_wpend;
  dtg_pkg::dtg_pins_t next_pins;
  logic          next_dqs_en;

  function automatic logic [XW-1:0] dn(input logic [XW-1:0] v);
    return (v != '0) ? v - 1'b1 : v;
  endfunction

  // ****************************************************
  // admission check
  // ****************************************************
  always_comb begin
    allowed = 1'b0;
    case (c)
      dtg_pkg::CMD_NOP:  allowed = 1'b1;
      dtg_pkg::CMD_ACT:  allowed = cke && (mrd == '0) && (xnr == '0)
                                   && (rrd == '0)
                                   && |(b_act & bsel);
      dtg_pkg::CMD_RD, dtg_pkg::CMD_RDA:
                         allowed = cke && (mrd == '0) && (ccd == '0)
                                   && (wtr == '0) && !wpend
                                   && (xrd == '0)
                                   && |(b_col & bsel);
      dtg_pkg::CMD_WR, dtg_pkg::CMD_WRA:
                         allowed = cke && (mrd == '0) && (ccd == '0)
                                   && (xnr == '0) && !wpend
                                   && |(b_col & bsel);
      dtg_pkg::CMD_PRE:  allowed = cke && (mrd == '0) && (xnr == '0)
                                   && |(b_pre & bsel);
      dtg_pkg::CMD_MRS, dtg_pkg::CMD_REF:
                         allowed = cke && (mrd == '0) && (xnr == '0)
                                   && all_closed;
      dtg_pkg::CMD_SRE, dtg_pkg::CMD_PDE:
                         allowed = cke && (mrd == '0) && (xnr == '0)
                                   && (cke_hold == '0)
                                   && !wpend;
      dtg_pkg::CMD_SRX, dtg_pkg::CMD_PDX, dtg_pkg::CMD_APDX:
                         allowed = !cke && (cke_hold == '0);
      default:           allowed = 1'b0;
    endcase
  end

  assign req_ready = allowed;
  assign go        = req_valid && allowed;

  // ****************************************************
  // per-bank timers
  // ****************************************************
  assign b_actp = (go && c == dtg_pkg::CMD_ACT) ? bsel : '0;
  assign b_rdp  = (go && is_rd) ? bsel : '0;
  assign b_wrp  = (go && is_wr) ? bsel : '0;
  assign b_prep = (go && c == dtg_pkg::CMD_PRE) ? bsel : '0;

  genvar g;
  generate
    for (g = 0; g < dtg_pkg::BANKS; g++) begin : g_bank
      dtg_bank_timer #(.CW(27), .WB(WRITE_LATENCY + BURST_LEN / 2))
      u_bank (
        .clock    (clock),
        .rst      (rst),
        .act      (b_actp[g]),
        .rd       (b_rdp[g]),
        .wr       (b_wrp[g]),
        .ap       (is_ap),
        .pre      (b_prep[g]),
        .open     (b_open[g]),
        .col_ok   (b_col[g]),
        .pre_ok   (b_pre[g]),
        .act_ok   (b_act[g]),
        .ras_late (b_late[g])
      );
    end
  endgenerate

  // ****************************************************
  // next state of shared counters and pins
  // ****************************************************
  always_comb begin
    next_mrd      = dn(mrd);
    next_rrd      = dn(rrd);
    next_ccd      = dn(ccd);
    next_wtr      = dn(wtr);
    next_xnr      = dn(xnr);
    next_xrd      = dn(xrd);
    next_cke_hold = dn(cke_hold);
    next_wl_cnt   = dn(wl_cnt);
    next_wpend    = wpend;
    next_cke      = cke;
    next_dqs_en   = 1'b0;
    // idle pins: deselect with clock enable as held
    next_pins       = '0;
    next_pins.cs_n  = 1'b1;
    next_pins.ras_n = 1'b1;
    next_pins.cas_n = 1'b1;
    next_pins.we_n  = 1'b1;
    // write strobe toggles from write latency through the burst;
    // at this clock rate the quarter-cycle window is met on the edge
    if (wpend) begin
      next_dqs_en = (wl_cnt <= XW'(BURST_LEN / 2));
      if (wl_cnt == XW'(1)) begin
        next_wpend = 1'b0;
        next_wtr   = XW'(dtg_pkg::TWTR_CK);
      end
    end
    if (go && c != dtg_pkg::CMD_NOP) begin
      next_pins.cs_n = 1'b0;
      next_pins.ba   = req.bank;
      next_pins.a    = req.addr;
      case (c)
        dtg_pkg::CMD_ACT: begin
          next_pins.ras_n = 1'b0;
          next_rrd = XW'(dtg_pkg::TRRD_CK - 1);
        end
        dtg_pkg::CMD_RD, dtg_pkg::CMD_RDA,
        dtg_pkg::CMD_WR, dtg_pkg::CMD_WRA: begin
          next_pins.cas_n = 1'b0;
          next_pins.we_n  = !is_wr;
          next_pins.a[10] = is_ap;
          next_ccd = XW'(dtg_pkg::TCCD_CK - 1);
          if (is_wr) begin
            next_wpend  = 1'b1;
            next_wl_cnt = XW'(WRITE_LATENCY + BURST_LEN / 2);
          end
        end
        dtg_pkg::CMD_PRE: begin
          next_pins.ras_n = 1'b0;
          next_pins.we_n  = 1'b0;
        end
        dtg_pkg::CMD_MRS: begin
          next_pins.ras_n = 1'b0;
          next_pins.cas_n = 1'b0;
          next_pins.we_n  = 1'b0;
          next_mrd = XW'(dtg_pkg::TMRD_CK - 1);
        end
        dtg_pkg::CMD_REF, dtg_pkg::CMD_SRE: begin
          next_pins.ras_n = 1'b0;
          next_pins.cas_n = 1'b0;
          if (c == dtg_pkg::CMD_REF) begin
            next_xnr = XW'(dtg_pkg::ceil_ck(dtg_pkg::TRFC_PS) - 1);
          end
        end
        default: begin
          next_pins.cs_n = 1'b1;
        end
      endcase
      case (c)
        dtg_pkg::CMD_SRE, dtg_pkg::CMD_PDE: begin
          next_cke      = 1'b0;
          next_cke_hold = XW'(dtg_pkg::TCKE_CK - 1);
        end
        dtg_pkg::CMD_SRX: begin
          next_cke      = 1'b1;
          next_cke_hold = XW'(dtg_pkg::TCKE_CK - 1);
          next_xnr = XW'(dtg_pkg::TXSNR_CK);
          next_xrd = XW'(XSRD);
        end
        dtg_pkg::CMD_PDX: begin
          next_cke      = 1'b1;
          next_cke_hold = XW'(dtg_pkg::TCKE_CK - 1);
          next_xnr = XW'(dtg_pkg::TXP_CK);
          next_xrd = XW'(dtg_pkg::TXP_CK);
        end
        dtg_pkg::CMD_APDX: begin
          next_cke      = 1'b1;
          next_cke_hold = XW'(dtg_pkg::TCKE_CK - 1);
          next_xrd = XW'(dtg_pkg::TXARD_CK);
          next_xnr = XW'(dtg_pkg::TXP_CK);
        end
        default: begin
          next_cke = cke;
        end
      endcase
    end
    next_pins.cke = next_cke;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      mrd      <= '0;
      rrd      <= '0;
      ccd      <= '0;
      wtr      <= '0;
      xnr      <= '0;
      xrd      <= '0;
      cke_hold <= '0;
      wl_cnt   <= '0;
      wpend    <= 1'b0;
      cke      <= 1'b1;
      dqs_en   <= 1'b0;
      pins     <= '{cke: 1'b1, cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1,
                    we_n: 1'b1, ba: '0, a: '0};
    end else begin
      mrd      <= next_mrd;
      rrd      <= next_rrd;
      ccd      <= next_ccd;
      wtr      <= next_wtr;
      xnr      <= next_xnr;
      xrd      <= next_xrd;
      cke_hold <= next_cke_hold;
      wl_cnt   <= next_wl_cnt;
      wpend    <= next_wpend;
      cke      <= next_cke;
      dqs_en   <= next_dqs_en;
      pins     <= next_pins;
    end
  end

  assign row_expire = |b_late;
  // is a property of the clock source; 25 ns lies outside the band
  localparam bit CLK_IN_RANGE = (dtg_pkg::CLK_PERIOD_PS >= dtg_pkg::TCK_MIN_PS)
    && (dtg_pkg::CLK_PERIOD_PS <= dtg_pkg::TCK_MAX_PS);
endmodule // dtg_ctrl
`default_nettype wire

// >>> dv/dtg_ctrl_monitor.sv
// checker: command spacing seen on the ddr2 command pins
`timescale 1ns/100ps
`default_nettype none
module dtg_ctrl_monitor #(
  parameter int WRITE_LATENCY = 3,
  parameter int BURST_LEN     = 4,
  parameter int XSRD          = 200
) (
  input wire logic               clock,      // controller clock
  input wire logic               rst,        // sync reset, high
  input wire dtg_pkg::dtg_req_t  req,        // requested command
  input wire logic               req_valid,  // request present
  input wire logic               req_ready,  // request legal now
  input wire dtg_pkg::dtg_pins_t pins,       // command pins
  input wire logic               dqs_en,     // write strobe window
  input wire logic               row_expire  // open row near limit
);
  localparam int P   = dtg_pkg::CLK_PERIOD_PS;
  localparam int WTR = WRITE_LATENCY + BURST_LEN / 2 + dtg_pkg::TWTR_CK;
  localparam int DAL = WRITE_LATENCY + BURST_LEN / 2
                     + (dtg_pkg::TWR_PS + P - 1) / P
                     + (dtg_pkg::TRP_PS + P - 1) / P;
  localparam int XNR = (dtg_pkg::TRFC_PS + dtg_pkg::TXSNR_EXTRA_PS + P - 1)
                     / P;
  logic       cmd;
  logic       act;
  logic       col;
  logic       rd;
  logic       wr;
  logic       pre;
  logic       mrs;
  logic       in_sr;
  logic [7:0] wtr_cnt;
  logic [7:0] dal_cnt;
  logic [7:0] nr_cnt;
  logic [7:0] rd_cnt;
  logic [7:0] since_wr;
  logic [2:0] dal_bank;

  function automatic logic [7:0] dn(input logic [7:0] v);
    return (v == 8'h00) ? v : v - 8'h01;
  endfunction

  // a nop is not a command: it may sit inside any wait
  assign cmd = !pins.cs_n && !(pins.ras_n && pins.cas_n && pins.we_n);
  assign act = cmd && !pins.ras_n && pins.cas_n && pins.we_n;
  assign col = cmd && pins.ras_n && !pins.cas_n;
  assign rd  = col && pins.we_n;
  assign wr  = col && !pins.we_n;
  assign pre = cmd && !pins.ras_n && pins.cas_n && !pins.we_n;
  assign mrs = cmd && !pins.ras_n && !pins.cas_n && !pins.we_n;

  always_ff @(posedge clock) begin
    if (rst) begin
      in_sr    <= 1'b0;
      wtr_cnt  <= 8'h00;
      dal_cnt  <= 8'h00;
      dal_bank <= 3'h0;
      nr_cnt   <= 8'h00;
      rd_cnt   <= 8'h00;
      since_wr <= 8'hff;
    end else begin
      wtr_cnt  <= wr ? 8'(WTR - 1) : dn(wtr_cnt);
      dal_cnt  <= (wr && pins.a[10]) ? 8'(DAL - 1) : dn(dal_cnt);
      dal_bank <= (wr && pins.a[10]) ? pins.ba : dal_bank;
      since_wr <= wr ? 8'h01 : ((since_wr == 8'hff) ? since_wr
                                                    : since_wr + 8'h01);
      nr_cnt   <= $rose(pins.cke) ? 8'((in_sr ? XNR : dtg_pkg::TXP_CK) - 1)
                                  : dn(nr_cnt);
      rd_cnt   <= $rose(pins.cke) ? 8'((in_sr ? XSRD : dtg_pkg::TXARD_CK) - 1)
                                  : dn(rd_cnt);
      in_sr    <= $rose(pins.cke) ? 1'b0
                : (in_sr || (cmd && !pins.ras_n && !pins.cas_n && !pins.cke));
    end
  end

  // ****************************************************
  // assertions
  // ****************************************************
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  a_mrs_gap: assert property (mrs |=> !cmd)
    else $error("command right after mode set");
  a_col_gap: assert property (col |=> !col)
    else $error("column commands one clock apart");
  a_ras_min: assert property (act |=> !(pre && (pins.a[10] || pins.ba == $past(pins.ba))))
    else $error("precharge too soon after activate");
  a_wtr_gap: assert property (rd |-> wtr_cnt == 8'h00)
    else $error("read too soon after write data");
  a_dal_gap: assert property (act && pins.ba == dal_bank |-> dal_cnt == 8'h00)
    else $error("activate inside write auto precharge time");
  a_exit_cmd: assert property (cmd && !rd |-> nr_cnt == 8'h00)
    else $error("command too soon after exit");
  a_exit_read: assert property (rd |-> rd_cnt == 8'h00)
    else $error("read too soon after exit");
  a_cke_hold: assert property ($changed(pins.cke) |=> $stable(pins.cke) [*2])
    else $error("clock enable pulse too short");
  a_dqs_start: assert property ($rose(dqs_en) |-> since_wr == 8'(WRITE_LATENCY) || since_wr == 8'(WRITE_LATENCY + 1))
    else $error("write strobe off write latency");
  a_idle_quiet: assert property (!(req_valid && req_ready) |=> !cmd && $stable(pins.cke))
    else $error("pins moved without a taken request");
  a_act_issue: assert property (req_valid && req_ready && req.cmd == dtg_pkg::CMD_ACT |=> act && pins.ba == $past(req.bank))
    else $error("activate not issued to requested bank");

  c_write: cover property (wr && !pins.a[10]);
  c_wr_ap: cover property (wr && pins.a[10]);
  c_sr_exit: cover property ($rose(pins.cke) && in_sr);
endmodule // dtg_ctrl_monitor

bind dtg_ctrl dtg_ctrl_monitor #(
  .WRITE_LATENCY(WRITE_LATENCY),
  .BURST_LEN    (BURST_LEN),
  .XSRD         (XSRD)
) mon (
  .clock     (clock),
  .rst       (rst),
  .req       (req),
  .req_valid (req_valid),
  .req_ready (req_ready),
  .pins      (pins),
  .dqs_en    (dqs_en),
  .row_expire(row_expire)
);
`default_nettype wire

// >>> dv/dtg_dram_model.sv
// device model: watches the command pins and tallies spacing faults
`timescale 1ns/100ps
`default_nettype none
module dtg_dram_model #(
  parameter int WRITE_LATENCY = 3,
  parameter int BURST_LEN     = 4,
  parameter int XSRD          = 200
) (
  input wire logic               clock,   // controller clock
  input wire logic               rst,     // sync reset, high
  input wire dtg_pkg::dtg_pins_t pins,    // command pins from controller
  output var int                 err_cnt  // spacing faults seen
);
  localparam int P    = dtg_pkg::CLK_PERIOD_PS;
  localparam int RAS  = (dtg_pkg::TRAS_MIN_PS + P - 1) / P;
  localparam int RASX = dtg_pkg::TRAS_MAX_PS / P;
  localparam int RCD  = (dtg_pkg::TRCD_PS + P - 1) / P;
  localparam int RRD  = (dtg_pkg::TRRD_PS + P - 1) / P;
  localparam int RTP  = (dtg_pkg::TRTP_PS + P - 1) / P;
  localparam int WR   = (dtg_pkg::TWR_PS + P - 1) / P;
  localparam int RP   = (dtg_pkg::TRP_PS + P - 1) / P;
  localparam int XNR  = (dtg_pkg::TRFC_PS + dtg_pkg::TXSNR_EXTRA_PS + P - 1)
                      / P;
  // stamps start far in the past; now never rewinds, even on reset
  int   now = 1000;
  int   t_mrs, t_col, t_act, t_wend, t_xnr, t_xrd, t_cke;
  int   t_open[8], t_rd[8], t_free[8];
  logic open_b[8];
  logic in_sr, cke_q, rd;
  logic [2:0] b;

  task automatic need(input logic ok);
    if (!ok) err_cnt++;
  endtask

  always @(posedge clock) begin
    now++;
    b  = pins.ba;
    rd = pins.ras_n && !pins.cas_n && pins.we_n;
    if (rst) begin
      err_cnt = 0;
      in_sr   = 1'b0;
      cke_q   = 1'b1;
      foreach (open_b[i]) open_b[i] = 1'b0;
    end else begin
      if (pins.cke !== cke_q) begin
        need(now - t_cke >= dtg_pkg::TCKE_CK);
        t_cke = now;
        if (pins.cke) begin
          t_xnr = now + (in_sr ? XNR : dtg_pkg::TXP_CK);
          t_xrd = now + (in_sr ? XSRD : dtg_pkg::TXARD_CK);
          in_sr = 1'b0;
        end
      end
      cke_q = pins.cke;
      if (!pins.cs_n && {pins.ras_n, pins.cas_n, pins.we_n} != 3'b111) begin
        need(now - t_mrs >= dtg_pkg::TMRD_CK);
        need(now >= (rd ? t_xrd : t_xnr));
        case ({pins.ras_n, pins.cas_n, pins.we_n})
          3'b011: begin
            need(!open_b[b] && now >= t_free[b]);
            need(now - t_act >= RRD);
            open_b[b] = 1'b1;
            t_open[b] = now;
            t_act = now;
          end
          3'b101, 3'b100: begin
            need(open_b[b] && now - t_open[b] >= RCD);
            need(now - t_col >= dtg_pkg::TCCD_CK);
            if (rd) need(now >= t_wend + dtg_pkg::TWTR_CK);
            if (rd) t_rd[b] = now;
            else t_wend = now + WRITE_LATENCY + BURST_LEN / 2;
            t_col = now;
            if (pins.a[10]) begin
              open_b[b] = 1'b0;
              t_free[b] = rd ? now + RTP + RP : t_wend + WR + RP;
            end
          end
          3'b010: for (int i = 0; i < 8; i++)
            if (open_b[i] && (pins.a[10] || i == int'(b))) begin
              need(now - t_open[i] >= RAS && now - t_open[i] <= RASX);
              need(now - t_rd[i] >= RTP);
              open_b[i] = 1'b0;
              t_free[i] = now + RP;
            end
          3'b000: t_mrs = now;
          3'b001: in_sr = !pins.cke;
          default: ;
        endcase
      end
    end
  end
endmodule // dtg_dram_model
`default_nettype wire

// >>> dv/testbench.sv
// testbench: command spacing scenarios for the ddr2 command issuer
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam int WL  = 3;
  localparam int BL  = 4;
  localparam int XS  = 10;   // shortened self refresh read wait
  localparam int WTR = WL + BL / 2 + dtg_pkg::TWTR_CK;
  logic               clock;
  logic               rst;
  dtg_pkg::dtg_req_t  req;
  logic               req_valid;
  logic               req_ready;
  dtg_pkg::dtg_pins_t pins;
  logic               dqs_en;
  logic               row_expire;
  int                 err_cnt;
  int                 miscompares = 0;
  int                 tests_run = 0;
  int                 cyc = 0;
  int                 wd = 0;

  dtg_ctrl #(.WRITE_LATENCY(WL), .BURST_LEN(BL), .XSRD(XS)) DUT (
    .clock(clock), .rst(rst), .req(req), .req_valid(req_valid),
    .req_ready(req_ready), .pins(pins), .dqs_en(dqs_en),
    .row_expire(row_expire));
  dtg_dram_model #(.WRITE_LATENCY(WL), .BURST_LEN(BL), .XSRD(XS)) mdl (
    .clock(clock), .rst(rst), .pins(pins), .err_cnt(err_cnt));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // counted on the falling edge so take stamps never race it
  always @(negedge clock) cyc <= cyc + 1;
  always @(posedge clock) begin
    wd++;
    if (wd == 2000) begin
      miscompares++;
      conclude();
    end
  end

  // ****************************************************
  // shared tasks
  // ****************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic gap(input int a, input int b, input int n);
    check(32'(b - a >= n), 32'h1);
  endtask
  // request held until a falling-edge look sees ready, taken next edge
  task automatic send(input dtg_pkg::dtg_cmd_t c, input logic [2:0] b,
                      output int t);
    int n = 0;
    req <= '{cmd: c, bank: b, addr: (c == dtg_pkg::CMD_RDA ||
             c == dtg_pkg::CMD_WRA) ? 14'h0400 : 14'h0000};
    req_valid <= 1'b1;
    @(negedge clock);
    while (req_ready !== 1'b1 && n < 100) begin
      @(negedge clock);
      n++;
    end
    check(32'(n < 100), 32'h1);
    @(posedge clock);
    t = cyc;
  endtask
  task automatic idle();
    req_valid <= 1'b0;
    @(posedge clock);
  endtask

  // ****************************************************
  // scenarios
  // ****************************************************
  task automatic t_reset();
    @(negedge clock);
    check(32'(pins.cs_n), 32'h1);
    check(32'(pins.cke), 32'h1);
    check(32'(dqs_en), 32'h0);
    @(posedge clock);
  endtask
  task automatic t_mrs();
    int a, b;
    send(dtg_pkg::CMD_MRS, 3'h0, a);
    send(dtg_pkg::CMD_REF, 3'h0, b);
    gap(a, b, dtg_pkg::TMRD_CK);
  endtask
  task automatic t_bank();
    int a0, a1, w1, w2, r, p;
    send(dtg_pkg::CMD_ACT, 3'h0, a0);
    send(dtg_pkg::CMD_ACT, 3'h1, a1);
    gap(a0, a1, mdl.RRD);
    send(dtg_pkg::CMD_WR, 3'h0, w1);
    gap(a0, w1, mdl.RCD);
    send(dtg_pkg::CMD_WR, 3'h0, w2);
    gap(w1, w2, dtg_pkg::TCCD_CK);
    send(dtg_pkg::CMD_RD, 3'h1, r);
    gap(w2, r, WTR);
    send(dtg_pkg::CMD_PRE, 3'h1, p);
    gap(r, p, mdl.RTP);
    gap(a1, p, mdl.RAS);
    send(dtg_pkg::CMD_WRA, 3'h0, w1);
    send(dtg_pkg::CMD_ACT, 3'h0, a0);
    gap(w1, a0, WL + BL / 2 + mdl.WR + mdl.RP);
    send(dtg_pkg::CMD_PRE, 3'h0, p);
    gap(a0, p, mdl.RAS);
  endtask
  // column command to a closed bank must wait forever, pins quiet
  task automatic t_refused();
    req <= '{cmd: dtg_pkg::CMD_RD, bank: 3'h5, addr: 14'h0000};
    req_valid <= 1'b1;
    repeat (20) begin
      @(negedge clock);
      check(32'(req_ready), 32'h0);
      check(32'(pins.cs_n), 32'h1);
    end
    @(posedge clock);
    idle();
  endtask
  task automatic t_selfref();
    int a, b, c, d;
    send(dtg_pkg::CMD_SRE, 3'h0, a);
    send(dtg_pkg::CMD_SRX, 3'h0, b);
    gap(a, b, dtg_pkg::TCKE_CK);
    send(dtg_pkg::CMD_ACT, 3'h2, c);
    gap(b, c, mdl.XNR);
    send(dtg_pkg::CMD_RDA, 3'h2, d);
    gap(b, d, XS);
    send(dtg_pkg::CMD_ACT, 3'h2, d);
  endtask
  task automatic t_pdown();
    int a, b, c;
    send(dtg_pkg::CMD_PDE, 3'h0, a);
    send(dtg_pkg::CMD_PDX, 3'h0, b);
    gap(a, b, dtg_pkg::TCKE_CK);
    send(dtg_pkg::CMD_ACT, 3'h3, c);
    gap(b, c, dtg_pkg::TXP_CK);
    send(dtg_pkg::CMD_PDE, 3'h0, a);
    send(dtg_pkg::CMD_APDX, 3'h0, b);
    send(dtg_pkg::CMD_RD, 3'h3, c);
    gap(b, c, dtg_pkg::TXARD_CK);
    send(dtg_pkg::CMD_PRE, 3'h3, c);
    idle();
  endtask

  initial begin
    rst = 1'b1;
    req_valid = 1'b0;
    req = '0;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    t_reset();
    t_refused();
    t_mrs();
    t_bank();
    t_selfref();
    t_pdown();
    repeat (4) @(posedge clock);
    check(32'(err_cnt), 32'h0);
    check(32'(row_expire), 32'h0);
    conclude();
  end
endmodule // testbench
`default_nettype wire
